// ==== design/tcc_pkg.sv ====
package tcc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NUM_CMP = 3;

  // register byte addresses; status and control aliases sit at +4 clear, +8 set, +c toggle
  localparam logic [15:0] OFS_STATUS = 16'h2300;
  localparam logic [15:0] OFS_CTRL1 = 16'h2310;
  localparam logic [15:0] OFS_CTRL2 = 16'h2330;
  localparam logic [15:0] OFS_CTRL3 = 16'h2350;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h2370;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h2380;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_TOGGLE = 2'h3;

  // per comparator control fields
  localparam int unsigned CTL_ENABLE = 15;
  localparam int unsigned CTL_PIN_EN = 14;
  localparam int unsigned CTL_INVERT = 13;
  localparam int unsigned CTL_EVENT = 9;
  localparam int unsigned CTL_RESULT = 8;
  localparam int unsigned CTL_EDGE_LSB = 6;
  localparam int unsigned CTL_POS_SEL = 4;
  localparam int unsigned CTL_NEG_LSB = 0;
  localparam logic [15:0] CTL_WRITABLE = 16'he0d3;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // shared status fields
  localparam int unsigned ST_EVT_LSB = 16;
  localparam int unsigned ST_HALT = 13;
  localparam int unsigned ST_REFSEL = 8;
  localparam int unsigned ST_OUT_LSB = 0;
  localparam logic [31:0] ST_WRITABLE = 32'h00002100;
  localparam logic [31:0] ST_RESET = 32'h00000000;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_STATUS,
    SEL_CTRL1,
    SEL_CTRL2,
    SEL_CTRL3,
    SEL_IRQ_STATUS,
    SEL_IRQ_MASK,
    SEL_NONE
  } tcc_sel_t;
endpackage : tcc_pkg

// ==== design/tcc_top.sv ====
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module tcc_top (
  input wire logic ref_clk_i, // 100 MHz peripheral clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic [2:0] comp_raw_i, // raw analog comparator results, asynchronous
  input wire logic idle_i, // device is in idle mode, same clock domain
  output logic [2:0] comparator_run_o, // analog comparator powered and running
  output logic [2:0] positive_input_select_o, // 1 internal reference, 0 input a
  output logic [5:0] negative_input_select_o, // two bits per comparator
  output logic reference_source_select_o, // 1 external reference pin, 0 band gap
  output logic [2:0] result_output_pin_o, // comparator result pins
  output logic [2:0] result_pin_oe_n_o, // low while a pin is driven
  output logic irq_o // level interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic tcc_pkg::tcc_sel_t tcc_decode(input logic [tcc_pkg::ADDR_W-1:0] a);
    tcc_pkg::tcc_sel_t s;
    s = tcc_pkg::SEL_NONE;
    if (a[15:4] == tcc_pkg::OFS_STATUS[15:4]) begin
      s = tcc_pkg::SEL_STATUS;
    end else if (a[15:4] == tcc_pkg::OFS_CTRL1[15:4]) begin
      s = tcc_pkg::SEL_CTRL1;
    end else if (a[15:4] == tcc_pkg::OFS_CTRL2[15:4]) begin
      s = tcc_pkg::SEL_CTRL2;
    end else if (a[15:4] == tcc_pkg::OFS_CTRL3[15:4]) begin
      s = tcc_pkg::SEL_CTRL3;
    end else if (a[15:2] == tcc_pkg::OFS_IRQ_STATUS[15:2]) begin
      s = tcc_pkg::SEL_IRQ_STATUS;
    end else if (a[15:2] == tcc_pkg::OFS_IRQ_MASK[15:2]) begin
      s = tcc_pkg::SEL_IRQ_MASK;
    end
    return s;
  endfunction : tcc_decode

  // alias write: plain, clear, set or toggle, limited to strobed bytes
  function automatic logic [31:0] tcc_apply(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb, input logic [1:0] op);
    logic [31:0] m;
    logic [31:0] r;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    case (op)
      tcc_pkg::OP_WRITE: r = (old & ~m) | (d & m);
      tcc_pkg::OP_CLEAR: r = old & ~(d & m);
      tcc_pkg::OP_SET: r = old | (d & m);
      tcc_pkg::OP_TOGGLE: r = old ^ (d & m);
      default: r = old;
    endcase
    return r;
  endfunction : tcc_apply

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] ctrl_q [3];
  logic [31:0] status_q;
  logic [2:0] evt_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [2:0] adj;
  logic [2:0] running;
  logic [2:0] trig;
  logic [2:0] result_mirror;
  logic [2:0] sw_clr_evt;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [tcc_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  tcc_pkg::tcc_sel_t wr_sel;
  tcc_pkg::tcc_sel_t rd_sel;
  logic [31:0] ctrl_word [3];
  logic [31:0] next_ctrl [3];
  logic [31:0] next_status;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data are parked independently

  assign s_axi_awready_o = ~aw_hold_q;
  assign s_axi_wready_o = ~w_hold_q;
  assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  assign wr_sel = tcc_decode(awaddr_q);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= tcc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_sel == tcc_pkg::SEL_NONE) ? tcc_pkg::RESP_SLVERR :
                         tcc_pkg::RESP_OKAY;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_sel = tcc_decode(s_axi_araddr_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= tcc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= tcc_pkg::RESP_OKAY;
      case (rd_sel)
        tcc_pkg::SEL_STATUS: s_axi_rdata_o <= status_word;
        tcc_pkg::SEL_CTRL1: s_axi_rdata_o <= ctrl_word[0];
        tcc_pkg::SEL_CTRL2: s_axi_rdata_o <= ctrl_word[1];
        tcc_pkg::SEL_CTRL3: s_axi_rdata_o <= ctrl_word[2];
        tcc_pkg::SEL_IRQ_STATUS: s_axi_rdata_o <= {29'h0, irq_st_q};
        tcc_pkg::SEL_IRQ_MASK: s_axi_rdata_o <= {29'h0, irq_mask_q};
        default: begin
          s_axi_rdata_o <= 32'h0;
          s_axi_rresp_o <= tcc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared status register

  // mirrors are assembled on read so software can never store into them
  always_comb begin
    status_word = status_q & tcc_pkg::ST_WRITABLE;
    status_word[tcc_pkg::ST_EVT_LSB +: 3] = evt_q;
    status_word[tcc_pkg::ST_OUT_LSB +: 3] = result_mirror;
  end

  assign next_status = tcc_apply(status_q, wdata_q, wstrb_q, awaddr_q[3:2]);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_q <= tcc_pkg::ST_RESET;
    end else if (wr_fire && wr_sel == tcc_pkg::SEL_STATUS) begin
      status_q <= next_status & tcc_pkg::ST_WRITABLE;
    end
  end

  assign reference_source_select_o = status_q[tcc_pkg::ST_REFSEL];

  //////////////////////////////////////////////////////////////////////////////
  // per comparator channels

  sequence s_rise(logic a, logic p);
    a && !p;
  endsequence

  sequence s_fall(logic a, logic p);
    !a && p;
  endsequence

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      logic [1:0] edge_sel;
      logic rise;
      logic fall;

      always_comb begin
        ctrl_word[g] = {16'h0, ctrl_q[g] & tcc_pkg::CTL_WRITABLE};
        ctrl_word[g][tcc_pkg::CTL_EVENT] = evt_q[g];
        ctrl_word[g][tcc_pkg::CTL_RESULT] = result_mirror[g];
      end

      assign next_ctrl[g] = tcc_apply(ctrl_word[g], wdata_q, wstrb_q, awaddr_q[3:2]);

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          ctrl_q[g] <= tcc_pkg::CTL_RESET;
        end else if (wr_fire && wr_sel == tcc_pkg::tcc_sel_t'(g + 1)) begin
          ctrl_q[g] <= next_ctrl[g][15:0] & tcc_pkg::CTL_WRITABLE;
        end
      end

      // enable gated by the idle halt request
      assign running[g] = ctrl_q[g][tcc_pkg::CTL_ENABLE] &
                          ~(status_q[tcc_pkg::ST_HALT] & idle_i);
      assign comparator_run_o[g] = running[g];
      assign positive_input_select_o[g] = ctrl_q[g][tcc_pkg::CTL_POS_SEL];
      assign negative_input_select_o[2*g +: 2] = ctrl_q[g][tcc_pkg::CTL_NEG_LSB +: 2];

      // the pin sees the raw result, so it may glitch; status never does
      assign result_output_pin_o[g] = running[g] & ctrl_q[g][tcc_pkg::CTL_PIN_EN] &
                                      (comp_raw_i[g] ^ ctrl_q[g][tcc_pkg::CTL_INVERT]);
      assign result_pin_oe_n_o[g] = ~(running[g] & ctrl_q[g][tcc_pkg::CTL_PIN_EN]);

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= comp_raw_i[g];
          sync2_q[g] <= sync1_q[g];
        end
      end

      assign adj[g] = sync2_q[g] ^ ctrl_q[g][tcc_pkg::CTL_INVERT];
      assign result_mirror[g] = running[g] & adj[g];

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          prev_q[g] <= 1'b0;
        end else begin
          prev_q[g] <= adj[g];
        end
      end

      assign edge_sel = ctrl_q[g][tcc_pkg::CTL_EDGE_LSB +: 2];
      assign rise = adj[g] & ~prev_q[g];
      assign fall = ~adj[g] & prev_q[g];

      always_comb begin
        case (edge_sel)
          tcc_pkg::EDGE_NONE: trig[g] = 1'b0;
          tcc_pkg::EDGE_RISE: trig[g] = rise;
          tcc_pkg::EDGE_FALL: trig[g] = fall;
          tcc_pkg::EDGE_ANY: trig[g] = rise | fall;
          default: trig[g] = 1'b0;
        endcase
        // an inversion change alone would fake an edge; this is accepted
        trig[g] = trig[g] & running[g] & ~evt_q[g];
      end

      // software clears the flag by any write that leaves it zero: plain write of zero, or a one through the clear or toggle alias
      assign sw_clr_evt[g] = wr_fire && wr_sel == tcc_pkg::tcc_sel_t'(g + 1) &&
                             !next_ctrl[g][tcc_pkg::CTL_EVENT];

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          evt_q[g] <= 1'b0;
        end else if (trig[g]) begin
          evt_q[g] <= 1'b1;
        end else if (sw_clr_evt[g]) begin
          evt_q[g] <= 1'b0;
        end
      end

      a_evt_blocks_trig: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_q[g] |-> !trig[g]) else $error("trigger while event flag set");
      a_evt_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_q[g] && !sw_clr_evt[g] |=> evt_q[g]) else $error("event flag dropped");
      a_rise_sets_evt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (running[g] && !evt_q[g] && edge_sel == tcc_pkg::EDGE_RISE)
        and s_rise(adj[g], prev_q[g])
        |=> evt_q[g]) else $error("rising edge missed");
      a_fall_sets_evt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (running[g] && !evt_q[g] && edge_sel == tcc_pkg::EDGE_FALL)
        and s_fall(adj[g], prev_q[g])
        |=> evt_q[g]) else $error("falling edge missed");
      a_none_no_evt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        edge_sel == tcc_pkg::EDGE_NONE && !evt_q[g] && !sw_clr_evt[g] |=> !evt_q[g])
        else $error("event with edge select none");
      a_off_idle_mirror: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ctrl_q[g][tcc_pkg::CTL_ENABLE] |-> !result_mirror[g] && !trig[g] &&
        result_pin_oe_n_o[g]) else $error("disabled comparator active");
      a_sync_two_flops: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> sync2_q[g] == $past(comp_raw_i[g], 2))
        else $error("synchroniser depth wrong");
      a_invert_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        running[g] |-> result_mirror[g] == (sync2_q[g] ^ ctrl_q[g][tcc_pkg::CTL_INVERT]))
        else $error("inversion not applied");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_st_q <= tcc_pkg::IRQ_RESET;
      irq_mask_q <= tcc_pkg::IRQ_RESET;
    end else begin
      // a new event in the clearing cycle survives the write of one
      if (wr_fire && wr_sel == tcc_pkg::SEL_IRQ_STATUS && wstrb_q[0]) begin
        irq_st_q <= (irq_st_q & ~wdata_q[2:0]) | trig;
      end else begin
        irq_st_q <= irq_st_q | trig;
      end
      if (wr_fire && wr_sel == tcc_pkg::SEL_IRQ_MASK && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[2:0];
      end
    end
  end

  assign irq_o = |(irq_st_q & irq_mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // bus level checks

  a_status_evt_mirror: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_axi_arvalid_i && s_axi_arready_o && rd_sel == tcc_pkg::SEL_STATUS
    |=> s_axi_rdata_o[18:16] == $past(evt_q) && s_axi_rdata_o[31:19] == 13'h0)
    else $error("status read lost event mirror");
  a_status_out_mirror: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_axi_arvalid_i && s_axi_arready_o && rd_sel == tcc_pkg::SEL_STATUS
    |=> s_axi_rdata_o[2:0] == $past(result_mirror)) else $error("status read lost result");
  a_reset_zero: assert property (@(posedge ref_clk_i)
    $past(rst_i) |-> status_q == 32'h0 && ctrl_q[0] == 16'h0 && ctrl_q[1] == 16'h0 &&
    ctrl_q[2] == 16'h0 && evt_q == 3'h0) else $error("register not zero after reset");
  a_write_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_fire |=> s_axi_bvalid_o && !aw_hold_q) else $error("write not answered");
  a_irq_follows_evt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    |trig |=> ##[0:1] |irq_st_q) else $error("event did not reach interrupt status");

endmodule : tcc_top

// ==== tb/tcc_analog_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcc_analog_model (
  input wire logic [2:0] level_i, // wanted result per comparator, bit0 = comparator one
  output logic [2:0] comp_raw_o // raw results, moving off the clock grid
);
  // an analog result settles some time after its inputs move, never on a clock edge,
  // so the design's synchroniser sees a truly asynchronous change
  initial begin
    comp_raw_o = 3'h0;
  end
  always @(level_i) begin
    comp_raw_o <= #3 level_i;
  end
endmodule : tcc_analog_model

// ==== tb/tcc_top_test.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcc_top_test;
  logic ref_clk_i, rst_i, idle, ref_sel, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, c;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] lvl, raw, run, pos_sel, pin, oe_n;
  logic [5:0] neg_sel;
  logic er, ef;
  int err_total, num_checks, cyc;

  tcc_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .comp_raw_i(raw), .idle_i(idle),
    .comparator_run_o(run), .positive_input_select_o(pos_sel),
    .negative_input_select_o(neg_sel), .reference_source_select_o(ref_sel),
    .result_output_pin_o(pin), .result_pin_oe_n_o(oe_n), .irq_o(irq));
  tcc_analog_model model_u (.level_i(lvl), .comp_raw_o(raw));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // the whole run needs about five hundred cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      $display("[ERR] run time expected below %0d cycles seen %0d", 6000, cyc);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // address and data go out together; each is dropped at the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk_i);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string nm);
    logic [31:0] g;
    rd(a, g);
    chk(nm, e, g);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, idle} = 6'h0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    lvl = 3'h0;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdc(tcc_pkg::OFS_STATUS, 32'h0, "status reset");
    rdc(tcc_pkg::OFS_CTRL1, 32'h0, "ctrl1 reset");
    rdc(tcc_pkg::OFS_CTRL2, 32'h0, "ctrl2 reset");
    rdc(tcc_pkg::OFS_CTRL3, 32'h0, "ctrl3 reset");
    rdc(tcc_pkg::OFS_IRQ_STATUS, 32'h0, "irq status reset");
    rdc(tcc_pkg::OFS_IRQ_MASK, 32'h0, "irq mask reset");
    rdc(16'h2360, 32'h0, "unmapped read");
    chk("unmapped read resp", 32'h2, {30'h0, r});
    wr(16'h2374, 32'h1);
    chk("unmapped write resp", 32'h2, {30'h0, r});
    $display("test reset_and_map done");

    wr(tcc_pkg::OFS_STATUS, 32'hffffffff);
    rdc(tcc_pkg::OFS_STATUS, 32'h00002100, "status");
    #1 chk("reference select", 32'h1, {31'h0, ref_sel});
    wr(tcc_pkg::OFS_STATUS + 16'h4, 32'h00000100);
    rdc(tcc_pkg::OFS_STATUS, 32'h00002000, "status clear alias");
    #1 chk("reference band gap", 32'h0, {31'h0, ref_sel});
    wr(tcc_pkg::OFS_CTRL2, 32'h000063d3);
    rdc(tcc_pkg::OFS_CTRL2, 32'h000060d3, "ctrl plain write");
    chk("ctrl2 selects", 32'h7, {29'h0, pos_sel[1], neg_sel[3:2]});
    wr(tcc_pkg::OFS_CTRL2 + 16'h4, 32'h000000c0);
    wr(tcc_pkg::OFS_CTRL2 + 16'h8, 32'h000000a0);
    rdc(tcc_pkg::OFS_CTRL2, 32'h00006093, "ctrl clear set alias");
    wr(tcc_pkg::OFS_CTRL2 + 16'hc, 32'h00006001);
    rdc(tcc_pkg::OFS_CTRL2, 32'h00000092, "ctrl toggle alias");
    wr(tcc_pkg::OFS_CTRL2, 32'h0);
    $display("test registers done");

    // rising edge events on comparator one, with the interrupt unmasked and masked
    wr(tcc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(tcc_pkg::OFS_CTRL1, 32'h00008040);
    lvl[0] <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rdc(tcc_pkg::OFS_CTRL1, 32'h00008340, "event and result");
    rdc(tcc_pkg::OFS_STATUS, 32'h00012001, "status mirrors");
    #1 chk("irq raised", 32'h1, {31'h0, irq});
    wr(tcc_pkg::OFS_IRQ_STATUS, 32'h1);
    lvl[0] <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rdc(tcc_pkg::OFS_STATUS, 32'h00012000, "result mirror low");
    lvl[0] <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rdc(tcc_pkg::OFS_IRQ_STATUS, 32'h0, "trigger while flag set");
    #1 chk("irq held off", 32'h0, {31'h0, irq});
    wr(tcc_pkg::OFS_CTRL1 + 16'h4, 32'h00000200);
    rdc(tcc_pkg::OFS_CTRL1, 32'h00008140, "flag cleared");
    wr(tcc_pkg::OFS_IRQ_MASK, 32'h0);
    lvl[0] <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    lvl[0] <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rdc(tcc_pkg::OFS_IRQ_STATUS, 32'h1, "irq status masked");
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(tcc_pkg::OFS_IRQ_MASK, 32'h1);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(tcc_pkg::OFS_IRQ_STATUS, 32'h1);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    wr(tcc_pkg::OFS_CTRL1, 32'h0);
    $display("test events done");

    // every edge select with both result polarities on comparator two
    for (int toggle_alias = 0; toggle_alias < 2; toggle_alias++) begin
      for (int m = 0; m < 4; m++) begin
        c = 32'h00008000 | (32'(toggle_alias) << 13) | (32'(m) << 6);
        er = (m == 3) || (m == 1 && toggle_alias == 0) || (m == 2 && toggle_alias == 1);
        ef = (m == 3) || (m == 2 && toggle_alias == 0) || (m == 1 && toggle_alias == 1);
        wr(tcc_pkg::OFS_CTRL2, c);
        repeat (5) @(posedge ref_clk_i);
        // rewriting drops any event that switching the channel on may have made
        wr(tcc_pkg::OFS_CTRL2, c);
        lvl[1] <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rd(tcc_pkg::OFS_CTRL2, v);
        chk("event on rise", {31'h0, er}, {31'h0, v[9]});
        wr(tcc_pkg::OFS_CTRL2, c);
        lvl[1] <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rd(tcc_pkg::OFS_CTRL2, v);
        chk("event on fall", {31'h0, ef}, {31'h0, v[9]});
        wr(tcc_pkg::OFS_CTRL2, 32'h0);
      end
    end
    $display("test edge select done");

    lvl[2] <= 1'b1;
    wr(tcc_pkg::OFS_CTRL3, 32'h0000c013);
    #1 chk("pin driven", 32'h1, {31'h0, pin[2]});
    chk("pin enable", 32'h0, {31'h0, oe_n[2]});
    chk("input select", 32'h7, {29'h0, pos_sel[2], neg_sel[5:4]});
    wr(tcc_pkg::OFS_CTRL3 + 16'h8, 32'h00002000);
    #1 chk("pin inverted", 32'h0, {31'h0, pin[2]});
    wr(tcc_pkg::OFS_STATUS, 32'h00002000);
    idle <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("halted in idle", 32'h0, {29'h0, run});
    chk("pin released", 32'h1, {31'h0, oe_n[2]});
    idle <= 1'b0;
    wr(tcc_pkg::OFS_CTRL3 + 16'h4, 32'h00008000);
    #1 chk("disabled", 32'h0, {29'h0, run});
    $display("test pins done");
    wrap_up();
  end
endmodule : tcc_top_test
